// *** src/sfp_device.sv ***
`timescale 1ns/1ps
// Behaviour
// - Clear-status command clears both error bits.
// - Clear-status is the single byte 0x50.
// - Busy falls when clear-status completes.
// - Page program starts with byte 0x41.
// - Second byte address middle, third address high.
// - Then 256 data bytes, lowest address first.
// - Received page is written to flash automatically.
// - Busy high while programming, low when ready.
// - Program outcome is recorded in status.
// - Sample on clock rise, transmit on fall.
// - Bytes are eight bits, least significant first.
// - Programmer waits for busy low between bytes.
// - While flash holds data without verified ID, both commands ignored.

// ****************************************************************
// Data FIFO
// ****************************************************************
module sfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = sfp_pkg::FIFO_WORDS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("FIFO depth must be a power of two of at least two.");
    end
  endgenerate
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  wire full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire push = in_valid && !full;
  wire pop = out_valid && out_ready;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else if (ce) begin
      if (push) begin
        mem_r[wr_ptr_r[AW-1:0]] <= in_data;
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

// ****************************************************************
// Device end: command interpreter
// ****************************************************************
module sfp_device #(
  parameter int FIFO_DEPTH = sfp_pkg::FIFO_WORDS
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  sfp_link_if.device LINK,
  input wire logic FLASH_HOLDS_DATA,
  input wire logic ID_VERIFIED,
  input wire logic ERASE_ERROR,
  output logic FLASH_WR_VALID,
  input wire logic FLASH_WR_READY,
  output logic [23:0] FLASH_WR_ADDR,
  output logic [7:0] FLASH_WR_DATA,
  output logic FLASH_PROG_REQ,
  output logic [23:0] FLASH_PROG_ADDR,
  input wire logic FLASH_PROG_DONE,
  input wire logic FLASH_PROG_FAIL,
  output logic [1:0] STATUS_ERR
);
  typedef enum logic [2:0] {ST_CMD, ST_ADDR_MID, ST_ADDR_HIGH, ST_DATA, ST_PROGRAM} sfp_state_e;

  // ****************************************************************
  // Link sampling
  // ****************************************************************
  logic clk_s1_r, clk_s2_r, clk_s3_r;
  logic rxd_s1_r, rxd_s2_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic byte_done_r;
  logic txd_r;
  wire link_rise = clk_s2_r && !clk_s3_r;
  wire link_fall = !clk_s2_r && clk_s3_r;

  // The transfer clock is slow against MCLK, so edges are found on the synchronised copy.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      clk_s1_r <= 1'b1;
      clk_s2_r <= 1'b1;
      clk_s3_r <= 1'b1;
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
      bit_cnt_r <= '0;
      shift_r <= '0;
      byte_done_r <= 1'b0;
      txd_r <= 1'b1;
    end else if (CE) begin
      clk_s1_r <= LINK.serial_transfer_clock_in;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      rxd_s1_r <= LINK.serial_receive_line;
      rxd_s2_r <= rxd_s1_r;
      byte_done_r <= link_rise && (bit_cnt_r == 3'd7);
      if (link_rise) begin
        shift_r <= {rxd_s2_r, shift_r[7:1]};
        bit_cnt_r <= bit_cnt_r + 3'd1;
      end
      // Neither command answers with data, so the line idles high and moves only on a fall.
      if (link_fall) begin
        txd_r <= 1'b1;
      end
    end
  end
  assign LINK.serial_transmit_line = txd_r;

  // ****************************************************************
  // Command sequencing
  // ****************************************************************
  sfp_state_e state_r, state_nxt;
  logic busy_r, busy_nxt;
  logic [15:0] page_r, page_nxt;
  logic [7:0] data_cnt_r, data_cnt_nxt;
  logic [8:0] wr_cnt_r;
  logic prog_req_r;
  logic [1:0] status_r;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;
  wire cmd_allowed = !FLASH_HOLDS_DATA || ID_VERIFIED;
  wire is_clear = byte_done_r && (state_r == ST_CMD) && (shift_r == sfp_pkg::CMD_CLEAR_STATUS) && cmd_allowed;
  wire is_program = (shift_r == sfp_pkg::CMD_PAGE_PROGRAM) && cmd_allowed;
  wire data_push = byte_done_r && (state_r == ST_DATA);
  wire wr_pop = fifo_out_valid && FLASH_WR_READY;
  wire page_drained = (wr_cnt_r == 9'(sfp_pkg::PAGE_BYTES));

  always_comb begin
    state_nxt = state_r;
    busy_nxt = busy_r;
    page_nxt = page_r;
    data_cnt_nxt = data_cnt_r;
    if (link_rise && (bit_cnt_r == 3'd0)) begin
      busy_nxt = 1'b1;
    end else if (byte_done_r) begin
      busy_nxt = 1'b0;
      case (state_r)
        ST_CMD: begin
          if (is_program) begin
            state_nxt = ST_ADDR_MID;
          end
        end
        ST_ADDR_MID: begin
          page_nxt = {page_r[15:8], shift_r};
          state_nxt = ST_ADDR_HIGH;
        end
        ST_ADDR_HIGH: begin
          page_nxt = {shift_r, page_r[7:0]};
          data_cnt_nxt = '0;
          state_nxt = ST_DATA;
        end
        ST_DATA: begin
          data_cnt_nxt = data_cnt_r + 8'd1;
          if (data_cnt_r == 8'(sfp_pkg::PAGE_BYTES - 1)) begin
            state_nxt = ST_PROGRAM;
            busy_nxt = 1'b1;
          end
        end
        default: begin
          busy_nxt = 1'b1;
        end
      endcase
    end else if ((state_r == ST_PROGRAM) && prog_req_r && FLASH_PROG_DONE) begin
      state_nxt = ST_CMD;
      busy_nxt = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state_r <= ST_CMD;
      busy_r <= 1'b0;
      page_r <= '0;
      data_cnt_r <= '0;
      wr_cnt_r <= '0;
      prog_req_r <= 1'b0;
      status_r <= sfp_pkg::STATUS_RESET;
    end else if (CE) begin
      state_r <= state_nxt;
      busy_r <= busy_nxt;
      page_r <= page_nxt;
      data_cnt_r <= data_cnt_nxt;
      if (state_r == ST_ADDR_HIGH) begin
        wr_cnt_r <= '0;
      end else if (wr_pop) begin
        wr_cnt_r <= wr_cnt_r + 9'd1;
      end
      // The flash starts only after every byte of the page has left the FIFO.
      if (prog_req_r && FLASH_PROG_DONE) begin
        prog_req_r <= 1'b0;
      end else if ((state_r == ST_PROGRAM) && page_drained) begin
        prog_req_r <= 1'b1;
      end
      // A setting event beats a clear arriving in the same cycle.
      status_r[0] <= (prog_req_r && FLASH_PROG_DONE && FLASH_PROG_FAIL) || (status_r[0] && !is_clear);
      status_r[1] <= ERASE_ERROR || (status_r[1] && !is_clear);
    end
  end

  sfp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) i_sfp_fifo (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .in_valid(data_push),
    .in_ready(fifo_in_ready),
    .in_data(shift_r),
    .out_valid(fifo_out_valid),
    .out_ready(FLASH_WR_READY),
    .out_data(fifo_out_data)
  );

  // A full FIFO holds busy high so the programmer cannot overrun it.
  assign LINK.busy_indicator_out = busy_r || !fifo_in_ready;
  assign FLASH_WR_VALID = fifo_out_valid;
  assign FLASH_WR_DATA = fifo_out_data;
  assign FLASH_WR_ADDR = {page_r, wr_cnt_r[7:0]};
  assign FLASH_PROG_ADDR = {page_r, sfp_pkg::ADDR_LOW_BYTE};
  assign FLASH_PROG_REQ = prog_req_r;
  assign STATUS_ERR = status_r;
endmodule

// *** src/sfp_host.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Host end: programmer link driver
// ****************************************************************
module sfp_host #(
  parameter int HALF_CYC = sfp_pkg::LINK_HALF_CYC,
  parameter int GUARD_CYC = sfp_pkg::BUSY_GUARD_CYC
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic CMD_PROGRAM,
  input wire logic [15:0] CMD_PAGE,
  input wire logic DATA_VALID,
  output logic DATA_READY,
  input wire logic [7:0] DATA_BYTE,
  sfp_link_if.host LINK
);
  generate
    if (HALF_CYC < 3 || GUARD_CYC < 6 || HALF_CYC > 65535 || GUARD_CYC > 65535) begin : g_bad_timing
      $error("Link half period or busy guard too short for the device sampler.");
    end
  endgenerate
  typedef enum logic [2:0] {H_IDLE, H_WAIT, H_LOW, H_HIGH, H_GUARD} sfp_host_e;
  sfp_host_e state_r;
  logic busy_s1_r, busy_s2_r;
  logic prog_r;
  logic [15:0] page_r;
  logic [8:0] idx_r;
  logic [7:0] byte_r;
  logic [2:0] bit_r;
  logic [15:0] tmr_r;
  logic sclk_r, rxd_r;
  wire tmr_done = (tmr_r == 16'd0);
  wire last_byte = prog_r ? (idx_r == sfp_pkg::IDX_LAST_PROGRAM) : (idx_r == sfp_pkg::IDX_CMD);
  wire need_data = prog_r && (idx_r > sfp_pkg::IDX_ADDR_HIGH);
  wire [7:0] cmd_code = prog_r ? sfp_pkg::CMD_PAGE_PROGRAM : sfp_pkg::CMD_CLEAR_STATUS;
  wire [7:0] next_byte = (idx_r == sfp_pkg::IDX_CMD) ? cmd_code :
                         (idx_r == sfp_pkg::IDX_ADDR_MID) ? page_r[7:0] :
                         (idx_r == sfp_pkg::IDX_ADDR_HIGH) ? page_r[15:8] : DATA_BYTE;
  wire can_send = (state_r == H_WAIT) && !busy_s2_r && (!need_data || DATA_VALID);

  assign CMD_READY = (state_r == H_IDLE);
  assign DATA_READY = can_send && need_data;

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state_r <= H_IDLE;
      busy_s1_r <= 1'b1;
      busy_s2_r <= 1'b1;
      prog_r <= 1'b0;
      page_r <= '0;
      idx_r <= '0;
      byte_r <= '0;
      bit_r <= '0;
      tmr_r <= '0;
      sclk_r <= 1'b1;
      rxd_r <= 1'b1;
    end else if (CE) begin
      busy_s1_r <= LINK.busy_indicator_out;
      busy_s2_r <= busy_s1_r;
      if (!tmr_done) begin
        tmr_r <= tmr_r - 16'd1;
      end
      case (state_r)
        H_IDLE: begin
          if (CMD_VALID) begin
            prog_r <= CMD_PROGRAM;
            page_r <= CMD_PAGE;
            idx_r <= sfp_pkg::IDX_CMD;
            state_r <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (can_send) begin
            byte_r <= next_byte;
            rxd_r <= next_byte[0];
            sclk_r <= 1'b0;
            bit_r <= '0;
            tmr_r <= 16'(HALF_CYC - 1);
            state_r <= H_LOW;
          end
        end
        H_LOW: begin
          if (tmr_done) begin
            sclk_r <= 1'b1;
            tmr_r <= 16'(HALF_CYC - 1);
            state_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tmr_done) begin
            if (bit_r == 3'd7) begin
              tmr_r <= 16'(GUARD_CYC - 1);
              state_r <= H_GUARD;
            end else begin
              bit_r <= bit_r + 3'd1;
              rxd_r <= byte_r[bit_r + 3'd1];
              sclk_r <= 1'b0;
              tmr_r <= 16'(HALF_CYC - 1);
              state_r <= H_LOW;
            end
          end
        end
        default: begin
          // The guard covers the round trip before the device's busy reaches this side.
          if (tmr_done) begin
            idx_r <= idx_r + 9'd1;
            state_r <= last_byte ? H_IDLE : H_WAIT;
          end
        end
      endcase
    end
  end

  assign LINK.serial_transfer_clock_in = sclk_r;
  assign LINK.serial_receive_line = rxd_r;
endmodule

// *** src/sfp_link_if.sv ***
`timescale 1ns/1ps
interface sfp_link_if;
  logic serial_transfer_clock_in;
  logic serial_receive_line;
  logic serial_transmit_line;
  logic busy_indicator_out;
  modport device (
    input serial_transfer_clock_in,
    input serial_receive_line,
    output serial_transmit_line,
    output busy_indicator_out
  );
  modport host (
    output serial_transfer_clock_in,
    output serial_receive_line,
    input serial_transmit_line,
    input busy_indicator_out
  );
endinterface

// *** src/sfp_pkg.sv ***
package sfp_pkg;
  localparam int BYTE_BITS = 8;
  localparam int PAGE_BYTES = 256;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h41;
  localparam logic [8:0] IDX_CMD = 9'h000;
  localparam logic [8:0] IDX_ADDR_MID = 9'h001;
  localparam logic [8:0] IDX_ADDR_HIGH = 9'h002;
  localparam logic [8:0] IDX_LAST_PROGRAM = 9'h102;
  localparam logic [7:0] ADDR_LOW_BYTE = 8'h00;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam int FIFO_WORDS = 32;
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int BUSY_GUARD_NS = 800;
  localparam int BUSY_GUARD_CYC = (BUSY_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// *** tb/sfp_link_bench.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module sfp_link_bench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_program = 1'b0;
  logic data_valid = 1'b0;
  logic [15:0] cmd_page = 16'h0000;
  logic [7:0] data_byte = 8'h00;
  logic holds = 1'b0;
  logic verified = 1'b0;
  logic erase_err = 1'b0;
  logic wr_ready = 1'b0;
  logic prog_done = 1'b0;
  logic prog_fail = 1'b0;
  logic stall = 1'b0;
  logic cmd_ready, data_ready, wr_valid, prog_req;
  logic [23:0] wr_addr, prog_addr;
  logic [7:0] wr_data;
  logic [1:0] status_err;
  logic [15:0] exp_page = 16'h0000;
  int wr_idx = 0;
  int bad_count = 0;
  int checks_done = 0;

  sfp_link_if link();
  always #50 mclk = ~mclk;

  sfp_host i_sfp_host (.MCLK(mclk), .RESET(reset), .CE(1'b1), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
    .CMD_PROGRAM(cmd_program), .CMD_PAGE(cmd_page), .DATA_VALID(data_valid), .DATA_READY(data_ready),
    .DATA_BYTE(data_byte), .LINK(link));
  sfp_device i_sfp_device (.MCLK(mclk), .RESET(reset), .CE(1'b1), .LINK(link), .FLASH_HOLDS_DATA(holds),
    .ID_VERIFIED(verified), .ERASE_ERROR(erase_err), .FLASH_WR_VALID(wr_valid), .FLASH_WR_READY(wr_ready),
    .FLASH_WR_ADDR(wr_addr), .FLASH_WR_DATA(wr_data), .FLASH_PROG_REQ(prog_req), .FLASH_PROG_ADDR(prog_addr),
    .FLASH_PROG_DONE(prog_done), .FLASH_PROG_FAIL(prog_fail), .STATUS_ERR(status_err));
  sfp_link_monitor i_mon (.MCLK(mclk), .RESET(reset), .serial_transfer_clock_in(link.serial_transfer_clock_in),
    .serial_receive_line(link.serial_receive_line), .serial_transmit_line(link.serial_transmit_line),
    .busy_indicator_out(link.busy_indicator_out));

  // ****************************************************************
  // Flash sink
  // ****************************************************************
  // Ready is set first, so the check sees the byte that the next rising edge pops.
  always @(negedge mclk) begin
    wr_ready = !stall;
    if (!reset && wr_valid === 1'b1 && wr_ready === 1'b1) begin
      `CHK(wr_addr, {exp_page, wr_idx[7:0]})
      `CHK(wr_data, wr_idx[7:0] ^ exp_page[7:0])
      wr_idx++;
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task send_cmd(input logic prog, input logic [15:0] page);
    @(negedge mclk);
    cmd_program = prog;
    cmd_page = page;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask

  task send_data(input logic [7:0] b);
    data_byte = b;
    data_valid = 1'b1;
    while (data_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
  endtask

  task wait_idle;
    while (cmd_ready !== 1'b1 || link.busy_indicator_out !== 1'b0) @(negedge mclk);
  endtask

  task t_refused;
    holds = 1'b1;
    @(negedge mclk);
    erase_err = 1'b1;
    @(negedge mclk);
    erase_err = 1'b0;
    send_cmd(1'b0, 16'h0000);
    wait_idle;
    `CHK(status_err, 2'h2)
    `CHK(wr_valid, 1'b0)
  endtask

  task t_clear;
    int n;
    verified = 1'b1;
    send_cmd(1'b0, 16'h0000);
    n = 0;
    while (link.busy_indicator_out !== 1'b1 && n < 200) begin
      n++;
      @(negedge mclk);
    end
    `CHK(link.busy_indicator_out, 1'b1)
    while (link.busy_indicator_out !== 1'b0) @(negedge mclk);
    `CHK(status_err, 2'h0)
    wait_idle;
    `CHK(status_err, 2'h0)
    `CHK(link.busy_indicator_out, 1'b0)
  endtask

  // Holding the sink lets the buffer fill, so busy must stay up while it is full.
  task t_program(input logic [15:0] page, input logic fail, input logic hold);
    int i;
    verified = 1'b1;
    exp_page = page;
    wr_idx = 0;
    stall = hold;
    if (hold) fork
      begin
        repeat (4000) @(negedge mclk);
        `CHK(link.busy_indicator_out, 1'b1)
        stall = 1'b0;
      end
    join_none
    send_cmd(1'b1, page);
    for (i = 0; i < 256; i++) send_data(i[7:0] ^ page[7:0]);
    data_valid = 1'b0;
    while (prog_req !== 1'b1) @(negedge mclk);
    `CHK(wr_idx, 256)
    `CHK(prog_addr, {page, 8'h00})
    `CHK(link.busy_indicator_out, 1'b1)
    prog_fail = fail;
    prog_done = 1'b1;
    @(negedge mclk);
    prog_done = 1'b0;
    prog_fail = 1'b0;
    `CHK(link.busy_indicator_out, 1'b0)
    `CHK(prog_req, 1'b0)
    `CHK(status_err[0], fail)
    wait_idle;
  endtask

  task wrap_up;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    t_refused;
    t_program(16'h12fe, 1'b0, 1'b1);
    t_program(16'hc301, 1'b1, 1'b0);
    t_clear;
    wrap_up;
  end

  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    wrap_up;
  end
endmodule

// *** tb/sfp_link_monitor.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Link checker
// ****************************************************************
module sfp_link_monitor (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic serial_transfer_clock_in,
  input wire logic serial_receive_line,
  input wire logic serial_transmit_line,
  input wire logic busy_indicator_out
);
  logic sclk_q_r;
  logic [3:0] fall_cnt_r;
  wire sclk_fall = sclk_q_r && !serial_transfer_clock_in;

  // Falls are counted from one busy release to the next, so a short or long byte shows up.
  always_ff @(posedge MCLK) begin
    sclk_q_r <= serial_transfer_clock_in;
    if (RESET || $fell(busy_indicator_out)) begin
      fall_cnt_r <= 4'h0;
    end else if (sclk_fall) begin
      fall_cnt_r <= fall_cnt_r + 4'h1;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_low_phase;
    !serial_transfer_clock_in [*4] ##1 serial_transfer_clock_in;
  endsequence
  sequence s_high_phase;
    serial_transfer_clock_in [*4];
  endsequence

  a_txd_held_high: assert property (serial_transmit_line)
    else $error("Transmit line left its idle level.");
  a_low_phase_len: assert property ($fell(serial_transfer_clock_in) |-> s_low_phase)
    else $error("Link clock low phase has the wrong length.");
  a_high_phase_len: assert property ($rose(serial_transfer_clock_in) |-> s_high_phase)
    else $error("Link clock high phase too short.");
  a_data_steady_high: assert property (serial_transfer_clock_in && $past(serial_transfer_clock_in)
    |-> $stable(serial_receive_line))
    else $error("Receive data moved while the link clock was high.");
  a_busy_after_start: assert property ($fell(serial_transfer_clock_in) && !busy_indicator_out
    |-> ##[1:12] busy_indicator_out)
    else $error("Busy did not rise after a byte started.");
  a_busy_holds_byte: assert property (!serial_transfer_clock_in && busy_indicator_out
    |=> busy_indicator_out)
    else $error("Busy dropped in the middle of a byte.");
  a_host_waits_busy: assert property ($fell(busy_indicator_out)
    |-> serial_transfer_clock_in [*2])
    else $error("Host restarted the link clock too soon after busy fell.");
  a_eight_bit_bytes: assert property ($fell(busy_indicator_out) |-> fall_cnt_r == 4'h8)
    else $error("A byte did not carry exactly eight clock pulses.");
endmodule
